// File: pkg/pmlc_pkg.sv
package pmlc_pkg;
  // register byte offsets
  localparam logic [7:0] PMLC_OFF_CONFIG = 8'h00;
  localparam logic [7:0] PMLC_OFF_ADC_CONFIG = 8'h04;
  localparam logic [7:0] PMLC_OFF_CURRENT = 8'h08;
  localparam logic [7:0] PMLC_OFF_VBUS = 8'h0C;
  localparam logic [7:0] PMLC_OFF_POWER = 8'h10;
  localparam logic [7:0] PMLC_OFF_TEMP = 8'h14;
  localparam logic [7:0] PMLC_OFF_CHARGE_LO = 8'h18;
  localparam logic [7:0] PMLC_OFF_CHARGE_HI = 8'h1C;
  localparam logic [7:0] PMLC_OFF_CUR_OVER_LIMIT = 8'h20;
  localparam logic [7:0] PMLC_OFF_BUS_OVER_VOLTAGE_THRESHOLD = 8'h24;
  localparam logic [7:0] PMLC_OFF_PWR_OVER_LIMIT = 8'h28;
  localparam logic [7:0] PMLC_OFF_TEMP_OVER_LIMIT = 8'h2C;
  localparam logic [7:0] PMLC_OFF_FAULT = 8'h30;

  // widths of results and limits
  localparam int PMLC_CUR_W = 20;
  localparam int PMLC_VBUS_W = 20;
  localparam int PMLC_PWR_W = 24;
  localparam int PMLC_TEMP_W = 16;
  localparam int PMLC_LIM_W = 16;
  localparam int PMLC_CHG_W = 40;

  // field positions
  localparam int PMLC_CFG_RUN_BIT = 0;       // continuous conversion enable
  localparam int PMLC_CFG_CHG_CLR_BIT = 1;   // write one: clear charge accumulator
  localparam int PMLC_ADC_TEMP_BIT = 0;
  localparam int PMLC_ADC_CUR_BIT = 1;
  localparam int PMLC_ADC_VBUS_BIT = 2;
  localparam int PMLC_FLT_CUR_BIT = 0;
  localparam int PMLC_FLT_VBUS_BIT = 1;
  localparam int PMLC_FLT_PWR_BIT = 2;
  localparam int PMLC_FLT_TEMP_BIT = 3;

  // values after reset
  localparam logic [31:0] PMLC_RST_CONFIG = 32'h0000_0001;
  localparam logic [31:0] PMLC_RST_ADC_CONFIG = 32'h0000_0007;
  localparam logic [15:0] PMLC_RST_SIGNED_LIMIT = 16'h7FFF;
  localparam logic [15:0] PMLC_RST_PWR_LIMIT = 16'hFFFF;

  // result scaling, for software conversion only
  localparam real PMLC_CUR_LSB_UA = 75.0;
  localparam real PMLC_VBUS_LSB_UV = 195.3125;
  localparam real PMLC_PWR_LSB_UW = 240.0;
  localparam real PMLC_TEMP_LSB_MDEGC = 7.8125;

  // axi responses
  localparam logic [1:0] PMLC_RESP_OKAY = 2'b00;
  localparam logic [1:0] PMLC_RESP_SLVERR = 2'b10;

  // conversion selector
  typedef enum logic [1:0] {
    PMLC_SEL_TEMP,
    PMLC_SEL_CUR,
    PMLC_SEL_VBUS
  } pmlc_sel_t;
endpackage : pmlc_pkg

// File: rtl/pmlc_cmp.sv
`timescale 1ns/1ps
module pmlc_cmp #(
  parameter int RES_W = 20,
  parameter int LIM_W = 16,
  parameter bit SIGNED_CMP = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic valid_i,
  input wire logic [RES_W-1:0] result_i,
  input wire logic [LIM_W-1:0] limit_i,
  output logic over_o
);
  logic [LIM_W-1:0] aligned;
  logic exceed;

  // the limit step is the weight of the upper result bits, so drop the low ones
  assign aligned = result_i[RES_W-1 -: LIM_W];
  assign exceed = SIGNED_CMP ? ($signed(aligned) > $signed(limit_i)) : (aligned > limit_i);

  // one-cycle pulse per completed result that is over the threshold
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      over_o <= 1'b0;
    end else if (ce_i) begin
      over_o <= valid_i && exceed;
    end
  end
endmodule : pmlc_cmp

// File: rtl/pmlc_seq.sv
`timescale 1ns/1ps
module pmlc_seq
  import pmlc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic run_i,
  input wire logic [2:0] enable_i,
  input wire logic done_i,
  output logic start_o,
  output pmlc_pkg::pmlc_sel_t sel_o
);
  import pmlc_pkg::*;

  typedef enum logic [1:0] {
    PMLC_ST_IDLE,
    PMLC_ST_START,
    PMLC_ST_WAIT
  } pmlc_seq_st_t;

  pmlc_seq_st_t state_q;
  pmlc_sel_t next_sel;

  // round robin over temperature, current and bus voltage
  always_comb begin
    next_sel = sel_o;
    case (sel_o)
      PMLC_SEL_TEMP: next_sel = enable_i[PMLC_ADC_CUR_BIT] ? PMLC_SEL_CUR :
                                enable_i[PMLC_ADC_VBUS_BIT] ? PMLC_SEL_VBUS : PMLC_SEL_TEMP;
      PMLC_SEL_CUR: next_sel = enable_i[PMLC_ADC_VBUS_BIT] ? PMLC_SEL_VBUS :
                               enable_i[PMLC_ADC_TEMP_BIT] ? PMLC_SEL_TEMP : PMLC_SEL_CUR;
      default: next_sel = enable_i[PMLC_ADC_TEMP_BIT] ? PMLC_SEL_TEMP :
                          enable_i[PMLC_ADC_CUR_BIT] ? PMLC_SEL_CUR : PMLC_SEL_VBUS;
    endcase
  end

  // free-running conversion loop, no host command needed after reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= PMLC_ST_IDLE;
      start_o <= 1'b0;
      sel_o <= PMLC_SEL_TEMP;
    end else if (ce_i) begin
      start_o <= 1'b0;
      case (state_q)
        PMLC_ST_IDLE: begin
          if (run_i && (enable_i != 3'h0)) begin
            state_q <= PMLC_ST_START;
            if (!enable_i[sel_o]) begin
              sel_o <= next_sel;
            end
          end
        end
        PMLC_ST_START: begin
          start_o <= 1'b1;
          state_q <= PMLC_ST_WAIT;
        end
        PMLC_ST_WAIT: begin
          // a started conversion always finishes, even if run drops
          if (done_i) begin
            sel_o <= next_sel;
            state_q <= PMLC_ST_IDLE;
          end
        end
        default: state_q <= PMLC_ST_IDLE;
      endcase
    end
  end
endmodule : pmlc_seq

// File: rtl/pmlc_top.sv
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// - after reset, defaults load and temperature, current, voltage convert continuously unasked
// - limits are 16 bits; current and voltage limits weigh sixteen result steps
// - current result is compared with the current over-limit threshold
// - current result step is 75 microamperes per bit
// - bus voltage result is compared with the bus overvoltage threshold
// - voltage, power, temperature results are fixed-step scaled integers
// - power result is 24 bits; its limit compares against upper sixteen bits
// - every limit returns to default at reset; host reprograms them
// - current, voltage, charge and temperature results are two's complement
module pmlc_top
  import pmlc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic conv_start_o,
  output pmlc_pkg::pmlc_sel_t conv_sel_o,
  input wire logic conv_done_i,
  input wire logic [23:0] conv_data_i,
  input wire logic pwr_valid_i,
  input wire logic [pmlc_pkg::PMLC_PWR_W-1:0] pwr_data_i,
  output logic [3:0] fault_o
);
  import pmlc_pkg::*;

  // bus slave state
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic [7:0] wr_off;

  // registers
  logic [31:0] config_q;
  logic [31:0] adc_config_q;
  logic [PMLC_LIM_W-1:0] cur_lim_q;
  logic [PMLC_LIM_W-1:0] vbus_lim_q;
  logic [PMLC_LIM_W-1:0] pwr_lim_q;
  logic [PMLC_LIM_W-1:0] temp_lim_q;
  logic [PMLC_CUR_W-1:0] cur_res_q;
  logic [PMLC_VBUS_W-1:0] vbus_res_q;
  logic [PMLC_PWR_W-1:0] pwr_res_q;
  logic [PMLC_TEMP_W-1:0] temp_res_q;
  logic [PMLC_CHG_W-1:0] charge_q;
  logic [3:0] fault_q;

  // result capture strobes and comparator pulses
  logic cur_done;
  logic vbus_done;
  logic temp_done;
  logic [3:0] over;
  logic chg_clr;
  logic [3:0] flt_clr;

  // merge write data into a register under the byte strobes
  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : strb_merge

  // a write proceeds once both address and data are held and no response is pending
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid_o;
  assign wr_off = {awaddr_q[7:2], 2'b00};
  assign chg_clr = wr_fire && (wr_off == PMLC_OFF_CONFIG) && wstrb_q[0]
                   && wdata_q[PMLC_CFG_CHG_CLR_BIT];
  assign flt_clr = (wr_fire && (wr_off == PMLC_OFF_FAULT) && wstrb_q[0]) ? wdata_q[3:0] : 4'h0;

  // write address and data channels, taken in either order
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      // readiness returns only after the response is taken: one write at a time
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // write response; unmapped or read-only offsets answer slverr
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= PMLC_RESP_OKAY;
    end else if (ce_i) begin
      if (wr_fire) begin
        s_axi_bvalid_o <= 1'b1;
        case (wr_off)
          PMLC_OFF_CONFIG, PMLC_OFF_ADC_CONFIG, PMLC_OFF_CUR_OVER_LIMIT,
          PMLC_OFF_BUS_OVER_VOLTAGE_THRESHOLD, PMLC_OFF_PWR_OVER_LIMIT,
          PMLC_OFF_TEMP_OVER_LIMIT, PMLC_OFF_FAULT: s_axi_bresp_o <= PMLC_RESP_OKAY;
          default: s_axi_bresp_o <= PMLC_RESP_SLVERR;
        endcase
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // configuration and limit registers; nothing survives a reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      config_q <= PMLC_RST_CONFIG;
      adc_config_q <= PMLC_RST_ADC_CONFIG;
      cur_lim_q <= PMLC_RST_SIGNED_LIMIT;
      vbus_lim_q <= PMLC_RST_SIGNED_LIMIT;
      pwr_lim_q <= PMLC_RST_PWR_LIMIT;
      temp_lim_q <= PMLC_RST_SIGNED_LIMIT;
    end else if (ce_i && wr_fire) begin
      case (wr_off)
        PMLC_OFF_CONFIG: begin
          // clear bit is a strobe only, it never reads back
          config_q <= strb_merge(config_q, wdata_q, wstrb_q) & 32'h0000_0001;
        end
        PMLC_OFF_ADC_CONFIG: adc_config_q <= strb_merge(adc_config_q, wdata_q, wstrb_q) & 32'h7;
        PMLC_OFF_CUR_OVER_LIMIT: begin
          cur_lim_q <= 16'(strb_merge({16'h0000, cur_lim_q}, wdata_q, wstrb_q));
        end
        PMLC_OFF_BUS_OVER_VOLTAGE_THRESHOLD: begin
          vbus_lim_q <= 16'(strb_merge({16'h0000, vbus_lim_q}, wdata_q, wstrb_q));
        end
        PMLC_OFF_PWR_OVER_LIMIT: begin
          pwr_lim_q <= 16'(strb_merge({16'h0000, pwr_lim_q}, wdata_q, wstrb_q));
        end
        PMLC_OFF_TEMP_OVER_LIMIT: begin
          temp_lim_q <= 16'(strb_merge({16'h0000, temp_lim_q}, wdata_q, wstrb_q));
        end
        default: ;
      endcase
    end
  end

  // conversion sequencer
  pmlc_seq u_seq (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .run_i(config_q[PMLC_CFG_RUN_BIT]),
    .enable_i(adc_config_q[2:0]),
    .done_i(conv_done_i),
    .start_o(conv_start_o),
    .sel_o(conv_sel_o)
  );

  assign cur_done = conv_done_i && (conv_sel_o == PMLC_SEL_CUR);
  assign vbus_done = conv_done_i && (conv_sel_o == PMLC_SEL_VBUS);
  assign temp_done = conv_done_i && (conv_sel_o == PMLC_SEL_TEMP);

  // result words, stored raw in scaled steps; power unsigned, the others two's complement
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_res_q <= '0;
      vbus_res_q <= '0;
      pwr_res_q <= '0;
      temp_res_q <= '0;
    end else if (ce_i) begin
      if (cur_done) begin
        cur_res_q <= conv_data_i[PMLC_CUR_W-1:0];
      end
      if (vbus_done) begin
        vbus_res_q <= conv_data_i[PMLC_VBUS_W-1:0];
      end
      if (pwr_valid_i) begin
        pwr_res_q <= pwr_data_i;
      end
      if (temp_done) begin
        temp_res_q <= conv_data_i[PMLC_TEMP_W-1:0];
      end
    end
  end

  // signed charge sum of current samples; a clear in the same cycle restarts from the sample
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      charge_q <= '0;
    end else if (ce_i) begin
      if (chg_clr) begin
        charge_q <= cur_done ? PMLC_CHG_W'($signed(conv_data_i[PMLC_CUR_W-1:0])) : '0;
      end else if (cur_done) begin
        charge_q <= charge_q + PMLC_CHG_W'($signed(conv_data_i[PMLC_CUR_W-1:0]));
      end
    end
  end

  // limit comparators; the incoming sample is compared in the same cycle it is captured
  pmlc_cmp #(.RES_W(PMLC_CUR_W), .LIM_W(PMLC_LIM_W), .SIGNED_CMP(1'b1)) u_cmp_cur (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .valid_i(cur_done),
    .result_i(conv_data_i[PMLC_CUR_W-1:0]), .limit_i(cur_lim_q),
    .over_o(over[PMLC_FLT_CUR_BIT])
  );
  pmlc_cmp #(.RES_W(PMLC_VBUS_W), .LIM_W(PMLC_LIM_W), .SIGNED_CMP(1'b1)) u_cmp_vbus (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .valid_i(vbus_done),
    .result_i(conv_data_i[PMLC_VBUS_W-1:0]), .limit_i(vbus_lim_q),
    .over_o(over[PMLC_FLT_VBUS_BIT])
  );
  pmlc_cmp #(.RES_W(PMLC_PWR_W), .LIM_W(PMLC_LIM_W), .SIGNED_CMP(1'b0)) u_cmp_pwr (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .valid_i(pwr_valid_i),
    .result_i(pwr_data_i), .limit_i(pwr_lim_q),
    .over_o(over[PMLC_FLT_PWR_BIT])
  );
  pmlc_cmp #(.RES_W(PMLC_TEMP_W), .LIM_W(PMLC_LIM_W), .SIGNED_CMP(1'b1)) u_cmp_temp (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .valid_i(temp_done),
    .result_i(conv_data_i[PMLC_TEMP_W-1:0]), .limit_i(temp_lim_q),
    .over_o(over[PMLC_FLT_TEMP_BIT])
  );

  // sticky faults, write one to clear; a new fault wins over its clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fault_q <= 4'h0;
      fault_o <= 4'h0;
    end else if (ce_i) begin
      fault_q <= (fault_q & ~flt_clr) | over;
      fault_o <= (fault_q & ~flt_clr) | over;
    end
  end

  // read channel: one read at a time, data one cycle after the address
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= PMLC_RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= PMLC_RESP_OKAY;
        case ({s_axi_araddr_i[7:2], 2'b00})
          PMLC_OFF_CONFIG: s_axi_rdata_o <= config_q;
          PMLC_OFF_ADC_CONFIG: s_axi_rdata_o <= adc_config_q;
          // signed results are sign extended so software sees a plain 32-bit value
          PMLC_OFF_CURRENT: s_axi_rdata_o <= 32'($signed(cur_res_q));
          PMLC_OFF_VBUS: s_axi_rdata_o <= 32'($signed(vbus_res_q));
          PMLC_OFF_POWER: s_axi_rdata_o <= {8'h00, pwr_res_q};
          PMLC_OFF_TEMP: s_axi_rdata_o <= 32'($signed(temp_res_q));
          PMLC_OFF_CHARGE_LO: s_axi_rdata_o <= charge_q[31:0];
          PMLC_OFF_CHARGE_HI: s_axi_rdata_o <= 32'($signed(charge_q[PMLC_CHG_W-1:32]));
          PMLC_OFF_CUR_OVER_LIMIT: s_axi_rdata_o <= {16'h0000, cur_lim_q};
          PMLC_OFF_BUS_OVER_VOLTAGE_THRESHOLD: s_axi_rdata_o <= {16'h0000, vbus_lim_q};
          PMLC_OFF_PWR_OVER_LIMIT: s_axi_rdata_o <= {16'h0000, pwr_lim_q};
          PMLC_OFF_TEMP_OVER_LIMIT: s_axi_rdata_o <= {16'h0000, temp_lim_q};
          PMLC_OFF_FAULT: s_axi_rdata_o <= {28'h0000000, fault_q};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= PMLC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end
endmodule : pmlc_top

// File: verification/pmlc_top_asserts.sv
`timescale 1ns/1ps
module pmlc_top_asserts
  import pmlc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic s_axi_rvalid_o,
  input wire logic conv_start_o,
  input wire pmlc_pkg::pmlc_sel_t conv_sel_o,
  input wire logic conv_done_i,
  input wire logic pwr_valid_i,
  input wire logic [3:0] fault_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // completions per quantity, so a fault can be traced to its own result
  logic cur_done, vb_done, tp_done;
  assign cur_done = conv_done_i && (conv_sel_o == PMLC_SEL_CUR);
  assign vb_done = conv_done_i && (conv_sel_o == PMLC_SEL_VBUS);
  assign tp_done = conv_done_i && (conv_sel_o == PMLC_SEL_TEMP);

  auto_start_a: assert property ($rose(rst_b_i) |-> ##[1:3] conv_start_o)
    else $error("no conversion started after reset");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  start_gap_a: assert property (conv_done_i |=> !conv_start_o [*2])
    else $error("start too soon after done");
  sel_hold_a: assert property (conv_start_o |=> $stable(conv_sel_o))
    else $error("selector moved during conversion");
  cur_fault_a: assert property ($rose(fault_o[0]) |-> $past(cur_done, 2) || $past(cur_done, 3))
    else $error("current fault without current result");
  vbus_fault_a: assert property ($rose(fault_o[1]) |-> $past(vb_done, 2) || $past(vb_done, 3))
    else $error("voltage fault without voltage result");
  pwr_fault_a: assert property ($rose(fault_o[2]) |-> $past(pwr_valid_i, 2) || $past(pwr_valid_i, 3))
    else $error("power fault without power result");
  temp_fault_a: assert property ($rose(fault_o[3]) |-> $past(tp_done, 2) || $past(tp_done, 3))
    else $error("temperature fault without temperature result");
  read_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
    else $error("read not answered next cycle");
  write_done_a: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
    else $error("write channel not reopened");
endmodule : pmlc_top_asserts

bind pmlc_top pmlc_top_asserts pmlc_top_asserts_i (.clk_i, .rst_b_i, .s_axi_awready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .conv_start_o, .conv_sel_o, .conv_done_i, .pwr_valid_i, .fault_o);

// File: verification/pmlc_fe_model.sv
`timescale 1ns/1ps
module pmlc_fe_model
  import pmlc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire pmlc_pkg::pmlc_sel_t sel_i,
  input wire logic [7:0] dly_i,
  input wire logic [19:0] cur_i,
  input wire logic [19:0] vbus_i,
  input wire logic [15:0] temp_i,
  output logic done_o,
  output logic [23:0] data_o
);
  logic [7:0] cnt_q;
  logic busy_q;

  // count out the conversion time, then hand back the selected sample
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'h0;
      cnt_q <= 8'h00;
      done_o <= 1'h0;
      data_o <= 24'h000000;
    end else begin
      done_o <= 1'h0;
      data_o <= ~data_o; // stale data must never pass for a sample
      if (start_i) begin
        busy_q <= 1'h1;
        cnt_q <= dly_i;
      end else if (busy_q && cnt_q != 8'h00) begin
        cnt_q <= cnt_q - 8'h01;
      end else if (busy_q) begin
        busy_q <= 1'h0;
        done_o <= 1'h1;
        case (sel_i)
          PMLC_SEL_CUR: data_o <= {{4{cur_i[19]}}, cur_i};
          PMLC_SEL_VBUS: data_o <= {{4{vbus_i[19]}}, vbus_i};
          default: data_o <= {{8{temp_i[15]}}, temp_i};
        endcase
      end
    end
  end
endmodule : pmlc_fe_model

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import pmlc_pkg::*;
  logic clk_i = 1'h0, rst_b_i = 1'h0, ce_i = 1'h1, s_axi_bready_i = 1'h1, s_axi_rready_i = 1'h1;
  logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_arvalid_i = 1'h0, pwr_valid_i = 1'h0;
  logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00, dly_v = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hF, fault_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic conv_start_o, conv_done_i;
  pmlc_sel_t conv_sel_o;
  logic [23:0] conv_data_i, pwr_data_i = 24'h0;
  logic [19:0] cur_v = 20'h0, vbus_v = 20'h0;
  logic [15:0] temp_v = 16'h0;
  int fail_count = 0;
  int checks_done = 0;

  pmlc_top pmlc_top_i (.clk_i, .rst_b_i, .ce_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
    .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
    .conv_start_o, .conv_sel_o, .conv_done_i, .conv_data_i, .pwr_valid_i, .pwr_data_i, .fault_o);
  pmlc_fe_model pmlc_fe_model_i (.clk_i, .rst_b_i, .start_i(conv_start_o), .sel_i(conv_sel_o),
    .dly_i(dly_v), .cur_i(cur_v), .vbus_i(vbus_v), .temp_i(temp_v), .done_o(conv_done_i),
    .data_o(conv_data_i));

  // 10 MHz
  always #50 clk_i = ~clk_i;

  task automatic give_verdict;
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // bready and rready stay high, so each answer is taken at the edge it shows
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'h0;
    w_ok = 1'h0;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (s_axi_awvalid_i && s_axi_awready_o === 1'h1) begin
        aw_ok = 1'h1;
        s_axi_awvalid_i <= 1'h0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o === 1'h1) begin
        w_ok = 1'h1;
        s_axi_wvalid_i <= 1'h0;
      end
    end
    do @(posedge clk_i); while (s_axi_bvalid_o !== 1'h1);
    check(32'(s_axi_bresp_o), 32'(er));
  endtask : wrc

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    do @(posedge clk_i); while (s_axi_arready_o !== 1'h1);
    s_axi_arvalid_i <= 1'h0;
    do @(posedge clk_i); while (s_axi_rvalid_o !== 1'h1);
    d = s_axi_rdata_o;
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    rd(a, d);
    check(d, e);
    check(32'(s_axi_rresp_o), 32'(er));
  endtask : rdc

  // wait for a fresh result of one quantity; the fault flag lands two cycles on
  task automatic conv(input pmlc_sel_t s);
    @(posedge clk_i); // a done launched before the new sample stood is stale
    do @(posedge clk_i); while (!(conv_done_i === 1'h1 && conv_sel_o === s));
    repeat (3) @(posedge clk_i);
  endtask : conv

  task automatic fchk(input int b, input logic e);
    logic [31:0] d;
    rd(PMLC_OFF_FAULT, d);
    check(32'(d[b]), 32'(e));
    check(32'(fault_o[b]), 32'(e));
  endtask : fchk

  task automatic fcase(input pmlc_sel_t s, input logic [19:0] v, input int b, input logic e);
    case (s)
      PMLC_SEL_CUR: cur_v <= v;
      PMLC_SEL_VBUS: vbus_v <= v;
      default: temp_v <= v[15:0];
    endcase
    conv(s);
    fchk(b, e);
  endtask : fcase

  task automatic pcase(input logic [23:0] v, input logic e);
    pwr_data_i <= v;
    pwr_valid_i <= 1'h1;
    @(posedge clk_i);
    pwr_valid_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    fchk(2, e);
  endtask : pcase

  // sticky flag survives the cause going away, then write one clears it
  task automatic fclear(input int b);
    fchk(b, 1'h1);
    wrc(PMLC_OFF_FAULT, 32'(1 << b), PMLC_RESP_OKAY);
    fchk(b, 1'h0);
  endtask : fclear

  task automatic t_defaults;
    logic [7:0] off [6];
    logic [31:0] val [6];
    off = '{PMLC_OFF_CONFIG, PMLC_OFF_ADC_CONFIG, PMLC_OFF_CUR_OVER_LIMIT,
      PMLC_OFF_BUS_OVER_VOLTAGE_THRESHOLD, PMLC_OFF_TEMP_OVER_LIMIT, PMLC_OFF_PWR_OVER_LIMIT};
    val = '{PMLC_RST_CONFIG, PMLC_RST_ADC_CONFIG, {16'h0, PMLC_RST_SIGNED_LIMIT},
      {16'h0, PMLC_RST_SIGNED_LIMIT}, {16'h0, PMLC_RST_SIGNED_LIMIT}, {16'h0, PMLC_RST_PWR_LIMIT}};
    for (int i = 0; i < 6; i++) begin
      rdc(off[i], val[i], PMLC_RESP_OKAY);
    end
    check(32'(fault_o), 32'h0);
  endtask : t_defaults

  task automatic t_refuse;
    rdc(8'h3C, 32'h0, PMLC_RESP_SLVERR);
    wrc(PMLC_OFF_CURRENT, 32'h1, PMLC_RESP_SLVERR);
    wrc(PMLC_OFF_PWR_OVER_LIMIT, 32'hFFFF_1234, PMLC_RESP_OKAY);
    rdc(PMLC_OFF_PWR_OVER_LIMIT, 32'h0000_1234, PMLC_RESP_OKAY);
  endtask : t_refuse

  // prompt front end; no command given, conversions run on their own
  task automatic t_results;
    dly_v <= 8'h00;
    cur_v <= 20'h3A980;
    vbus_v <= 20'h0F000;
    temp_v <= 16'h2A80;
    conv(PMLC_SEL_CUR);
    conv(PMLC_SEL_VBUS);
    conv(PMLC_SEL_TEMP);
    rdc(PMLC_OFF_CURRENT, 32'h0003_A980, PMLC_RESP_OKAY);
    rdc(PMLC_OFF_VBUS, 32'h0000_F000, PMLC_RESP_OKAY);
    rdc(PMLC_OFF_TEMP, 32'h0000_2A80, PMLC_RESP_OKAY);
    cur_v <= 20'hC5680;
    temp_v <= 16'hD580;
    conv(PMLC_SEL_CUR);
    conv(PMLC_SEL_TEMP);
    rdc(PMLC_OFF_CURRENT, 32'hFFFC_5680, PMLC_RESP_OKAY);
    rdc(PMLC_OFF_TEMP, 32'hFFFF_D580, PMLC_RESP_OKAY);
    pcase(24'h0DBBA0, 1'h0);
    rdc(PMLC_OFF_POWER, 32'h000D_BBA0, PMLC_RESP_OKAY);
  endtask : t_results

  // slow front end; negative, equal and one-over samples against the limit
  task automatic t_cur_fault;
    dly_v <= 8'h14;
    wrc(PMLC_OFF_CUR_OVER_LIMIT, 32'h445C, PMLC_RESP_OKAY);
    fcase(PMLC_SEL_CUR, 20'h80000, 0, 1'h0);
    fcase(PMLC_SEL_CUR, 20'h445CF, 0, 1'h0);
    fcase(PMLC_SEL_CUR, 20'h445D0, 0, 1'h1);
    fcase(PMLC_SEL_CUR, 20'h00000, 0, 1'h1);
    fclear(0);
  endtask : t_cur_fault

  task automatic t_vbus_fault;
    wrc(PMLC_OFF_BUS_OVER_VOLTAGE_THRESHOLD, 32'h0F00, PMLC_RESP_OKAY);
    fcase(PMLC_SEL_VBUS, 20'h0F00F, 1, 1'h0);
    fcase(PMLC_SEL_VBUS, 20'h0F010, 1, 1'h1);
    fcase(PMLC_SEL_VBUS, 20'h00000, 1, 1'h1);
    fclear(1);
  endtask : t_vbus_fault

  task automatic t_pwr_fault;
    wrc(PMLC_OFF_PWR_OVER_LIMIT, 32'h0DBB, PMLC_RESP_OKAY);
    pcase(24'h0DBBFF, 1'h0);
    pcase(24'h0DBC00, 1'h1);
    pcase(24'h000000, 1'h1);
    fclear(2);
  endtask : t_pwr_fault

  task automatic t_temp_fault;
    wrc(PMLC_OFF_TEMP_OVER_LIMIT, 32'h2A80, PMLC_RESP_OKAY);
    fcase(PMLC_SEL_TEMP, 20'h02A80, 3, 1'h0);
    fcase(PMLC_SEL_TEMP, 20'h02A81, 3, 1'h1);
    fcase(PMLC_SEL_TEMP, 20'h00000, 3, 1'h1);
    fclear(3);
  endtask : t_temp_fault

  // a second power cycle must bring back every default
  task automatic t_power_cycle;
    rst_b_i <= 1'h0;
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'h1;
    @(posedge clk_i);
    t_defaults();
    wrc(PMLC_OFF_CONFIG, 32'h3, PMLC_RESP_OKAY);
    rdc(PMLC_OFF_CONFIG, 32'h1, PMLC_RESP_OKAY);
  endtask : t_power_cycle

  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'h1;
    @(posedge clk_i);
    t_defaults();
    t_refuse();
    t_results();
    t_cur_fault();
    t_vbus_fault();
    t_pwr_fault();
    t_temp_fault();
    t_power_cycle();
    give_verdict();
  end

  // whole run needs about a thousand cycles; this is ample
  initial begin
    repeat (30000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end
endmodule : tb
